//--- pkg/sprc_consts.vh
/*
 * Register offsets, field positions, reset values and timing counts of
 * the sleep and power reduction controller.
 * Assumes inclusion by bare name from the logic/ design files.
 */
`ifndef SPRC_CONSTS_VH
`define SPRC_CONSTS_VH

// ********************
// Register map (word index, byte address = 4 * index)
// ********************
`define SPRC_IDX_SLEEP_CTRL 8'h33
`define SPRC_IDX_MCU_CTRL 8'h34
`define SPRC_IDX_POWER_RED 8'h35
`define SPRC_IDX_CORE_CTRL 8'h36
`define SPRC_IDX_STATUS 8'h37

// ********************
// Field positions
// ********************
`define SPRC_SE_BIT 0
`define SPRC_SM_LSB 1
`define SPRC_SM_MSB 3
`define SPRC_BROWNOUT_SLEEP_UNLOCK_BIT 5
`define SPRC_BROWNOUT_SLEEP_OFF_BIT 6
`define SPRC_JTD_BIT 7
`define SPRC_PR_ADC_BIT 0
`define SPRC_PR_USART_BIT 1
`define SPRC_PR_SPI_BIT 2
`define SPRC_PR_TIM1_BIT 3

// ********************
// Reset values and mode codes
// ********************
`define SPRC_SLEEP_CTRL_RST 8'h00
`define SPRC_MCU_CTRL_RST 8'h00
`define SPRC_POWER_RED_RST 8'h00
`define SPRC_SM_IDLE 3'h0
`define SPRC_SM_ADCNR 3'h1
`define SPRC_SM_PDOWN 3'h2
`define SPRC_SM_PSAVE 3'h3
`define SPRC_SM_STANDBY 3'h6

// ********************
// Timing counts in clock cycles
// ********************
`define SPRC_BROWNOUT_SLEEP_OFF_WINDOW 3'h4
`define SPRC_BROWNOUT_SLEEP_OFF_DELAY 3'h3
`define SPRC_BROWNOUT_SLEEP_OFF_HOLD 3'h3
`define SPRC_STANDBY_WAKE 8'h06
`define SPRC_IRQ_HALT 8'h04

`endif

//--- logic/sprc_brownout_sleep_off_seq.v
/*
 * Timed unlock sequence for the brown-out sleep-off control bit.
 * Assumes write pulses from the register slave on the same clock.
 */
`timescale 1ns/1ps
`include "sprc_consts.vh"

module sprc_brownout_sleep_off_seq
(
   input wire clock,
   input wire rst,
   input wire wr_mcu,
   input wire [7:0] wdata,
   output reg brownout_sleep_off_active_ff
);

reg [2:0] win_ff;
reg [2:0] dly_ff;
reg [2:0] hold_ff;
reg pend_ff;
reg [2:0] nxt_win;

// ********************
// Unlock window, then delayed activation and self clear
// ********************
always @*
begin
   nxt_win = win_ff;
   if (wr_mcu && wdata[`SPRC_BROWNOUT_SLEEP_OFF_BIT] && wdata[`SPRC_BROWNOUT_SLEEP_UNLOCK_BIT])
   begin
      nxt_win = `SPRC_BROWNOUT_SLEEP_OFF_WINDOW;
   end
   else if (win_ff != 3'h0)
   begin
      nxt_win = win_ff - 3'h1;
   end
end

always @(posedge clock or posedge rst)
begin
   if (rst)
   begin
      win_ff <= 3'h0;
      dly_ff <= 3'h0;
      hold_ff <= 3'h0;
      pend_ff <= 1'b0;
      brownout_sleep_off_active_ff <= 1'b0;
   end
   else
   begin
      win_ff <= nxt_win;
      if (wr_mcu && wdata[`SPRC_BROWNOUT_SLEEP_OFF_BIT] && !wdata[`SPRC_BROWNOUT_SLEEP_UNLOCK_BIT]
         && win_ff != 3'h0)
      begin
         pend_ff <= 1'b1;
         dly_ff <= `SPRC_BROWNOUT_SLEEP_OFF_DELAY - 3'h1;
         win_ff <= 3'h0;
      end
      else if (pend_ff)
      begin
         if (dly_ff == 3'h0)
         begin
            pend_ff <= 1'b0;
            brownout_sleep_off_active_ff <= 1'b1;
            hold_ff <= `SPRC_BROWNOUT_SLEEP_OFF_HOLD - 3'h1;
         end
         else
         begin
            dly_ff <= dly_ff - 3'h1;
         end
      end
      else if (brownout_sleep_off_active_ff)
      begin
         if (hold_ff == 3'h0)
         begin
            brownout_sleep_off_active_ff <= 1'b0;
         end
         else
         begin
            hold_ff <= hold_ff - 3'h1;
         end
      end
   end
end

endmodule // sprc_brownout_sleep_off_seq

//--- logic/sprc_wake_timer.v
/*
 * Down counter giving the wake-up halt length in cycles.
 * Assumes a one-cycle load pulse; done pulses when the count expires.
 */
`timescale 1ns/1ps

module sprc_wake_timer
#(
   parameter WIDTH = 8
)
(
   input wire clock,
   input wire rst,
   input wire load,
   input wire [WIDTH-1:0] count,
   output reg busy_ff,
   output reg done_ff
);

reg [WIDTH-1:0] cnt_ff;

always @(posedge clock or posedge rst)
begin
   if (rst)
   begin
      cnt_ff <= {WIDTH{1'b0}};
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
   end
   else
   begin
      done_ff <= 1'b0;
      if (load)
      begin
         cnt_ff <= count;
         busy_ff <= 1'b1;
      end
      else if (busy_ff)
      begin
         if (cnt_ff <= {{(WIDTH-1){1'b0}}, 1'b1})
         begin
            busy_ff <= 1'b0;
            done_ff <= 1'b1;
         end
         else
         begin
            cnt_ff <= cnt_ff - {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end
end

endmodule // sprc_wake_timer

//--- logic/sprc_power_ctrl.v
/*
 * Sleep mode and power reduction controller: register slave, sleep
 * state machine, clock gates and power enables.
 * Assumes an Avalon-MM master on the same clock, a one-cycle sleep
 * instruction pulse from the core and level wake-up requests.
 */
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
`include "sprc_consts.vh"

// How it works
// - Standby code with crystal keeps oscillator running
// - Standby wake-up takes six cycles
// - Set reduction bit stops peripheral clock, freezes
// - Clearing bit restarts clock, state kept
// - Module gating applies in active and idle
// - Input buffers except wake pins off when io and adc stopped
// - Debug fuse with scan port enabled keeps clock in down/save modes
// - Disable bit or unprogrammed fuse disables scan port
// - Scan output undriven when not shifting
// - Mode field bits 3:1 decode five modes
// - Sleep only when sleep enable bit is one
// - Timed two-write unlock within four cycles
// - Sleep-off active after three, clears three later
// - Reduction bits 7:4 read zero
// - Bit 3 stops the 16-bit timer
// - Bit 2 stops the serial peripheral clock
// - Bit 1 stops the async serial clock
// - Bit 0 stops converter; comparator loses mux
// - Enabled converter stays on; restart is extended
// - Comparator off in deep modes; reference kept
// - Enabled watchdog runs in every mode
// - Interrupt wake halts four extra cycles
// - Brown-out detector re-enabled on wake
module sprc_power_ctrl
#(
   parameter STARTUP_CYCLES = 8'h10
)
(
   input wire clock,
   input wire rst,
   input wire [7:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   input wire sleep_instr,
   input wire wake_irq,
   input wire crystal_sel,
   input wire onchip_debug_fuse,
   input wire scan_port_fuse,
   input wire brownout_level_fuse,
   input wire adc_enabled,
   input wire wdt_enabled,
   input wire comp_uses_ref,
   input wire tap_shifting,
   input wire tdo_data,
   output reg cpu_clk_en_ff,
   output reg io_clk_en_ff,
   output reg adc_clk_en_ff,
   output reg osc_run_ff,
   output reg timer1_clk_en_ff,
   output reg spi_clk_en_ff,
   output reg usart_clk_en_ff,
   output reg adc_pwr_en_ff,
   output reg adc_mux_avail_ff,
   output reg adc_extended_ff,
   output reg comp_en_ff,
   output reg vref_en_ff,
   output reg wdt_run_ff,
   output reg bod_en_ff,
   output reg in_buf_en_ff,
   output reg wake_pin_buf_en_ff,
   output reg scan_port_en_ff,
   output reg tdo_out_ff,
   output reg tdo_oe_ff,
   output reg irq_ack_ff,
   output reg sleeping_ff
);

// ********************
// States
// ********************
localparam ST_RUN = 4'b0001;
localparam ST_SLEEP = 4'b0010;
localparam ST_WAKE = 4'b0100;
localparam ST_HALT = 4'b1000;

reg [7:0] sleep_ctrl_ff;
reg [7:0] mcu_ctrl_ff;
reg [7:0] power_red_ff;
reg [3:0] state_ff;
reg [3:0] nxt_state;
reg [2:0] mode_ff;
reg bod_off_ff;
reg adc_was_off_ff;
reg rd_pend_ff;
wire brownout_sleep_off_active;
wire wake_busy;
wire wake_done;
wire halt_busy;
wire halt_done;
reg wake_load;
reg halt_load;
reg [7:0] wake_count;
wire [2:0] sm_code;
wire mode_legal;
wire acc;
wire wr_mcu;

assign sm_code = sleep_ctrl_ff[`SPRC_SM_MSB:`SPRC_SM_LSB];
assign acc = (avs_read || avs_write) && avs_waitrequest;
assign wr_mcu = avs_write && avs_waitrequest
   && avs_address == `SPRC_IDX_MCU_CTRL;

// Legal mode code; standby also needs a crystal
function legal_mode;
   input [2:0] code;
   input xtal;
   begin
      case (code)
         `SPRC_SM_IDLE, `SPRC_SM_ADCNR, `SPRC_SM_PDOWN, `SPRC_SM_PSAVE:
            legal_mode = 1'b1;
         `SPRC_SM_STANDBY: legal_mode = xtal;
         default: legal_mode = 1'b0;
      endcase
   end
endfunction

// Mode that stops both io and converter clocks
function deep_mode;
   input [2:0] code;
   begin
      deep_mode = code != `SPRC_SM_IDLE && code != `SPRC_SM_ADCNR;
   end
endfunction

assign mode_legal = legal_mode(sm_code, crystal_sel);

// ********************
// Register slave
// ********************
always @(posedge clock or posedge rst)
begin
   if (rst)
   begin
      sleep_ctrl_ff <= `SPRC_SLEEP_CTRL_RST;
      mcu_ctrl_ff <= `SPRC_MCU_CTRL_RST;
      power_red_ff <= `SPRC_POWER_RED_RST;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      rd_pend_ff <= 1'b0;
   end
   else
   begin
      avs_waitrequest <= 1'b1;
      rd_pend_ff <= 1'b0;
      if (acc && !rd_pend_ff)
      begin
         avs_waitrequest <= 1'b0;
         rd_pend_ff <= 1'b1;
         avs_readdata <= 32'h0;
         case (avs_address)
            `SPRC_IDX_SLEEP_CTRL:
            begin
               avs_readdata <= {24'h0, 4'h0, sleep_ctrl_ff[3:0]};
               if (avs_write)
               begin
                  sleep_ctrl_ff <= {4'h0, avs_writedata[3:0]};
               end
            end
            `SPRC_IDX_MCU_CTRL:
            begin
               avs_readdata <= {24'h0, mcu_ctrl_ff[7], brownout_sleep_off_active,
                  mcu_ctrl_ff[5:0]};
               if (avs_write)
               begin
                  mcu_ctrl_ff <= {avs_writedata[7], 1'b0,
                     avs_writedata[5:0]};
               end
            end
            `SPRC_IDX_POWER_RED:
            begin
               avs_readdata <= {24'h0, 4'h0, power_red_ff[3:0]};
               if (avs_write)
               begin
                  power_red_ff <= {4'h0, avs_writedata[3:0]};
               end
            end
            `SPRC_IDX_STATUS:
            begin
               avs_readdata <= {24'h0, bod_en_ff, adc_extended_ff,
                  mode_ff, state_ff[2:0]};
            end
            default:
            begin
               avs_readdata <= 32'h0;
            end
         endcase
      end
   end
end

// ********************
// Helpers
// ********************
sprc_brownout_sleep_off_seq u_brownout_sleep_off
(
   .clock(clock),
   .rst(rst),
   .wr_mcu(wr_mcu),
   .wdata(avs_writedata[7:0]),
   .brownout_sleep_off_active_ff(brownout_sleep_off_active)
);

sprc_wake_timer #(.WIDTH(8)) u_wake
(
   .clock(clock),
   .rst(rst),
   .load(wake_load),
   .count(wake_count),
   .busy_ff(wake_busy),
   .done_ff(wake_done)
);

sprc_wake_timer #(.WIDTH(8)) u_halt
(
   .clock(clock),
   .rst(rst),
   .load(halt_load),
   .count(`SPRC_IRQ_HALT),
   .busy_ff(halt_busy),
   .done_ff(halt_done)
);

// ********************
// Sleep state machine
// ********************
always @*
begin
   nxt_state = state_ff;
   wake_load = 1'b0;
   halt_load = 1'b0;
   wake_count = STARTUP_CYCLES[7:0];
   if (mode_ff == `SPRC_SM_STANDBY)
   begin
      wake_count = `SPRC_STANDBY_WAKE;
   end
   case (state_ff)
      ST_RUN:
      begin
         if (sleep_instr && sleep_ctrl_ff[`SPRC_SE_BIT] && mode_legal)
         begin
            nxt_state = ST_SLEEP;
         end
      end
      ST_SLEEP:
      begin
         if (wake_irq)
         begin
            nxt_state = ST_WAKE;
            wake_load = 1'b1;
         end
      end
      ST_WAKE:
      begin
         if (wake_done)
         begin
            nxt_state = ST_HALT;
            halt_load = 1'b1;
         end
      end
      ST_HALT:
      begin
         if (halt_done)
         begin
            nxt_state = ST_RUN;
         end
      end
      default:
      begin
         nxt_state = ST_RUN;
      end
   endcase
end

always @(posedge clock or posedge rst)
begin
   if (rst)
   begin
      state_ff <= ST_RUN;
      mode_ff <= `SPRC_SM_IDLE;
      bod_off_ff <= 1'b0;
      irq_ack_ff <= 1'b0;
      sleeping_ff <= 1'b0;
   end
   else
   begin
      state_ff <= nxt_state;
      irq_ack_ff <= state_ff == ST_HALT && halt_done;
      sleeping_ff <= nxt_state != ST_RUN;
      if (state_ff == ST_RUN && nxt_state == ST_SLEEP)
      begin
         mode_ff <= sm_code;
         bod_off_ff <= brownout_sleep_off_active && deep_mode(sm_code);
      end
      else if (state_ff == ST_SLEEP && nxt_state == ST_WAKE)
      begin
         bod_off_ff <= 1'b0;
      end
   end
end

// ********************
// Clock gates and power enables
// ********************
always @(posedge clock or posedge rst)
begin
   if (rst)
   begin
      cpu_clk_en_ff <= 1'b1;
      io_clk_en_ff <= 1'b1;
      adc_clk_en_ff <= 1'b1;
      osc_run_ff <= 1'b1;
      timer1_clk_en_ff <= 1'b1;
      spi_clk_en_ff <= 1'b1;
      usart_clk_en_ff <= 1'b1;
      adc_pwr_en_ff <= 1'b1;
      adc_mux_avail_ff <= 1'b1;
      adc_extended_ff <= 1'b0;
      adc_was_off_ff <= 1'b0;
      comp_en_ff <= 1'b1;
      vref_en_ff <= 1'b0;
      wdt_run_ff <= 1'b0;
      bod_en_ff <= 1'b0;
      in_buf_en_ff <= 1'b1;
      wake_pin_buf_en_ff <= 1'b1;
      scan_port_en_ff <= 1'b0;
      tdo_out_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
   end
   else
   begin : gates
      reg slp;
      reg io_on;
      reg adc_on;
      slp = state_ff == ST_SLEEP;
      io_on = !slp || mode_ff == `SPRC_SM_IDLE;
      adc_on = io_on || mode_ff == `SPRC_SM_ADCNR;
      cpu_clk_en_ff <= state_ff == ST_RUN;
      io_clk_en_ff <= io_on;
      adc_clk_en_ff <= adc_on;
      osc_run_ff <= adc_on || mode_ff == `SPRC_SM_STANDBY
         || (onchip_debug_fuse && scan_port_en_ff);
      timer1_clk_en_ff <= io_on && !power_red_ff[`SPRC_PR_TIM1_BIT];
      spi_clk_en_ff <= io_on && !power_red_ff[`SPRC_PR_SPI_BIT];
      usart_clk_en_ff <= io_on && !power_red_ff[`SPRC_PR_USART_BIT];
      adc_pwr_en_ff <= !power_red_ff[`SPRC_PR_ADC_BIT];
      adc_mux_avail_ff <= !power_red_ff[`SPRC_PR_ADC_BIT];
      adc_was_off_ff <= !adc_enabled || power_red_ff[`SPRC_PR_ADC_BIT];
      if (adc_was_off_ff && adc_enabled
         && !power_red_ff[`SPRC_PR_ADC_BIT])
      begin
         adc_extended_ff <= 1'b1;
      end
      else if (adc_clk_en_ff && adc_enabled && !adc_was_off_ff)
      begin
         adc_extended_ff <= 1'b0;
      end
      comp_en_ff <= !(slp && deep_mode(mode_ff));
      vref_en_ff <= comp_uses_ref || adc_enabled
         || (brownout_level_fuse && !bod_off_ff);
      wdt_run_ff <= wdt_enabled;
      bod_en_ff <= brownout_level_fuse && !bod_off_ff;
      in_buf_en_ff <= adc_on;
      wake_pin_buf_en_ff <= 1'b1;
      scan_port_en_ff <= scan_port_fuse && !mcu_ctrl_ff[`SPRC_JTD_BIT];
      tdo_out_ff <= tdo_data;
      tdo_oe_ff <= scan_port_en_ff && tap_shifting;
   end
end

// Stopped peripheral clocks hold state, registers simply retain value
// Re-enabled clocks resume from frozen state

endmodule // sprc_power_ctrl

//--- verification/sprc_monitor.sv
/* Port checker of the sleep and power reduction controller.
   Assumes a bind onto sprc_power_ctrl; one clock domain. */
`timescale 1ns/1ps
module sprc_monitor
(
   input wire clock,
   input wire rst,
   input wire [7:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [31:0] avs_readdata,
   input wire avs_waitrequest,
   input wire sleep_instr,
   input wire wake_irq,
   input wire wdt_enabled,
   input wire tap_shifting,
   input wire cpu_clk_en_ff,
   input wire io_clk_en_ff,
   input wire timer1_clk_en_ff,
   input wire comp_en_ff,
   input wire wdt_run_ff,
   input wire in_buf_en_ff,
   input wire wake_pin_buf_en_ff,
   input wire tdo_oe_ff,
   input wire sleeping_ff
);
   // ********************
   // Register shadows
   // ********************
   reg [3:0] sm_ff;
   reg [3:0] pr_ff;
   reg [2:0] ent_ff;
   wire wr_done;
   assign wr_done = avs_write && !avs_waitrequest;
   always @(posedge clock or posedge rst)
      if (rst)
      begin
         sm_ff <= 4'h0;
         pr_ff <= 4'h0;
         ent_ff <= 3'h0;
      end
      else
      begin
         if (wr_done && avs_address == 8'h33)
            sm_ff <= avs_writedata[3:0];
         if (wr_done && avs_address == 8'h35)
            pr_ff <= avs_writedata[3:0];
         if (sleep_instr && !sleeping_ff)
            ent_ff <= sm_ff[3:1];
      end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   AST_BUS_ONE: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not one cycle");
   AST_PR_RSV: assert property (
      avs_read && !avs_waitrequest && avs_address == 8'h35
      |-> avs_readdata[31:4] == 28'h0) else $error("reserved bits set");
   AST_TIM_OFF: assert property (pr_ff[3] [*3] |-> !timer1_clk_en_ff)
      else $error("timer clock not gated");
   AST_TIM_ON: assert property (
      (!pr_ff[3] && io_clk_en_ff) [*3] |-> timer1_clk_en_ff)
      else $error("timer clock not restarted");
   AST_NO_SE: assert property (
      sleep_instr && !sleeping_ff && !sm_ff[0] |=> !sleeping_ff)
      else $error("sleep without enable");
   AST_RSV: assert property (
      sleep_instr && !sleeping_ff && sm_ff[3] && sm_ff[2:1] != 2'h2
      |=> !sleeping_ff) else $error("reserved code slept");
   AST_ENTER: assert property (
      sleep_instr && !sleeping_ff && sm_ff[0] && !sm_ff[3]
      |=> sleeping_ff ##1 !cpu_clk_en_ff) else $error("sleep not entered");
   AST_DEEP: assert property (
      ((sleeping_ff && !wake_irq) [*3]) ##0 ent_ff[1]
      |-> !comp_en_ff && !in_buf_en_ff && wake_pin_buf_en_ff)
      else $error("deep sleep enables wrong");
   AST_WDT: assert property (wdt_enabled |=> wdt_run_ff)
      else $error("watchdog stopped");
   AST_TDO: assert property ((!tap_shifting) [*2] |-> !tdo_oe_ff)
      else $error("scan out driven while idle");
endmodule // sprc_monitor

bind sprc_power_ctrl sprc_monitor sprc_monitor_i (.clock, .rst,
   .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
   .avs_waitrequest, .sleep_instr, .wake_irq, .wdt_enabled, .tap_shifting,
   .cpu_clk_en_ff, .io_clk_en_ff, .timer1_clk_en_ff, .comp_en_ff,
   .wdt_run_ff, .in_buf_en_ff, .wake_pin_buf_en_ff, .tdo_oe_ff,
   .sleeping_ff);

//--- verification/sprc_core_model.sv
/* Core model: issues the sleep instruction and raises a wake request.
   Assumes the controller acknowledges a wake with a one-cycle pulse. */
`timescale 1ns/1ps
module sprc_core_model
(
   input wire clock,
   input wire rst,
   input wire irq_ack_ff,
   output reg sleep_instr,
   output reg wake_irq
);
   initial
   begin
      sleep_instr = 1'b0;
      wake_irq = 1'b0;
   end
   task exec_sleep;
      @(posedge clock);
      sleep_instr <= 1'b1;
      @(posedge clock);
      sleep_instr <= 1'b0;
   endtask
   task raise_irq(input int d);
      repeat (d) @(posedge clock);
      @(posedge clock);
      wake_irq <= 1'b1;
   endtask
   // Request stays pending until the routine is let run
   always @(posedge clock)
      if (rst || irq_ack_ff)
         wake_irq <= 1'b0;
endmodule // sprc_core_model

//--- verification/sprc_power_ctrl_tb.sv
/* Self-checking bench of the sleep and power reduction controller.
   Assumes the core model drives the sleep and wake lines. */
`timescale 1ns/1ps
`include "sprc_consts.vh"
module sprc_power_ctrl_tb;
   localparam SU = 8;
   reg clock, rst, avs_read, avs_write, crystal_sel, onchip_debug_fuse;
   reg scan_port_fuse, wdt_enabled, tap_shifting;
   reg brownout_level_fuse, adc_enabled, comp_uses_ref, tdo_data;
   reg [7:0] avs_address;
   reg [31:0] avs_writedata, rdv;
   wire [31:0] avs_readdata;
   wire avs_waitrequest, sleep_instr, wake_irq, cpu_clk_en_ff, io_clk_en_ff;
   wire adc_clk_en_ff, osc_run_ff, timer1_clk_en_ff, spi_clk_en_ff;
   wire usart_clk_en_ff, adc_pwr_en_ff, adc_mux_avail_ff, adc_extended_ff;
   wire comp_en_ff, vref_en_ff, wdt_run_ff, bod_en_ff, in_buf_en_ff;
   wire wake_pin_buf_en_ff, scan_port_en_ff, tdo_out_ff, tdo_oe_ff;
   wire irq_ack_ff, sleeping_ff;
   wire [3:0] gates;
   int n_errors, cmp_count, cyc;
   int nw [5];
   assign gates = {timer1_clk_en_ff, spi_clk_en_ff, usart_clk_en_ff,
      adc_pwr_en_ff};
   sprc_power_ctrl #(.STARTUP_CYCLES(SU)) sprc_power_ctrl_i (.clock, .rst,
      .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .sleep_instr, .wake_irq, .crystal_sel,
      .onchip_debug_fuse, .scan_port_fuse, .brownout_level_fuse,
      .adc_enabled, .wdt_enabled, .comp_uses_ref, .tap_shifting, .tdo_data,
      .cpu_clk_en_ff, .io_clk_en_ff, .adc_clk_en_ff, .osc_run_ff,
      .timer1_clk_en_ff, .spi_clk_en_ff, .usart_clk_en_ff, .adc_pwr_en_ff,
      .adc_mux_avail_ff, .adc_extended_ff, .comp_en_ff, .vref_en_ff,
      .wdt_run_ff, .bod_en_ff, .in_buf_en_ff, .wake_pin_buf_en_ff,
      .scan_port_en_ff, .tdo_out_ff, .tdo_oe_ff, .irq_ack_ff, .sleeping_ff);
   sprc_core_model sprc_core_model_i (.clock, .rst, .irq_ack_ff,
      .sleep_instr, .wake_irq);
   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         summarize;
      end
   end
   task summarize;
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input string nm, input [31:0] e, input [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         n_errors++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task cy(input int n);
      repeat (n) @(posedge clock);
   endtask
   task bus(input w, input [7:0] a, input [7:0] d);
      @(posedge clock);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {24'h0, d};
      @(posedge clock);
      while (avs_waitrequest !== 1'b0)
         @(posedge clock);
      rdv = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task wake_up(input int d, output int n);
      sprc_core_model_i.raise_irq(d);
      n = 0;
      while (irq_ack_ff !== 1'b1)
      begin
         @(posedge clock);
         n++;
      end
      cy(3);
      chk("awake", 0, sleeping_ff);
   endtask
   task t_regs;
      bus(0, 8'h33, 0);
      chk("sleep_mode_control", `SPRC_SLEEP_CTRL_RST, rdv);
      bus(1, 8'h36, 8'hff);
      bus(0, 8'h36, 0);
      chk("unmapped", 0, rdv);
      chk("wdt_run", 1, wdt_run_ff);
      chk("vref", 1, vref_en_ff);
   endtask
   task t_prr;
      reg [7:0] v;
      for (int i = 0; i < 6; i++)
      begin
         v = (i == 4) ? 8'hff : ((i == 5) ? 8'h00 : 8'h01 << i);
         bus(1, 8'h35, v);
         bus(0, 8'h35, 0);
         chk("prr", v & 8'h0f, rdv);
         cy(3);
         chk("gates", 4'hf ^ v[3:0], gates);
         chk("mux", !v[0], adc_mux_avail_ff);
      end
   endtask
   task t_refuse;
      reg [7:0] sv [5] = '{8'h00, 8'h09, 8'h0b, 8'h0f, 8'h0d};
      for (int i = 0; i < 5; i++)
      begin
         bus(1, 8'h33, sv[i]);
         sprc_core_model_i.exec_sleep;
         cy(3);
         chk("no_sleep", 0, sleeping_ff);
      end
   endtask
   task t_modes;
      reg [2:0] m;
      reg [2:0] ml [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
      crystal_sel <= 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         m = ml[i];
         bus(1, 8'h33, {4'h0, m, 1'b1});
         sprc_core_model_i.exec_sleep;
         cy(4);
         chk("sleep", 1, sleeping_ff);
         chk("cpu", 0, cpu_clk_en_ff);
         chk("io", m == 0, io_clk_en_ff);
         chk("timer1", m == 0, timer1_clk_en_ff);
         chk("inbuf", m < 2, in_buf_en_ff);
         chk("adcclk", m < 2, adc_clk_en_ff);
         chk("wakepin", 1, wake_pin_buf_en_ff);
         chk("comp", m < 2, comp_en_ff);
         chk("osc", m < 2 || m == 6, osc_run_ff);
         wake_up(i % 2, nw[i]);
         bus(1, 8'h33, 8'h00);
      end
      chk("sby_wake", nw[2] - SU + 6, nw[4]);
   endtask
   task t_debug;
      int n;
      onchip_debug_fuse <= 1'b1;
      scan_port_fuse <= 1'b1;
      bus(1, 8'h33, 8'h07);
      sprc_core_model_i.exec_sleep;
      cy(4);
      chk("osc_dbg", 1, osc_run_ff);
      wake_up(2, n);
      onchip_debug_fuse <= 1'b0;
      scan_port_fuse <= 1'b0;
   endtask
   task t_brownout_sleep_off;
      int n;
      bus(1, 8'h34, 8'h60);
      cy(5);
      bus(1, 8'h34, 8'h40);
      bus(0, 8'h34, 0);
      bus(0, 8'h34, 0);
      chk("brownout_sleep_off_late", 0, rdv[6]);
      bus(1, 8'h34, 8'h60);
      bus(1, 8'h34, 8'h40);
      bus(0, 8'h34, 0);
      bus(0, 8'h34, 0);
      chk("brownout_sleep_off_on", 1, rdv[6]);
      cy(6);
      bus(0, 8'h34, 0);
      chk("brownout_sleep_off_clr", 0, rdv[6]);
      bus(1, 8'h33, 8'h05);
      bus(1, 8'h34, 8'h60);
      bus(1, 8'h34, 8'h40);
      cy(2);
      sprc_core_model_i.exec_sleep;
      cy(4);
      chk("bod_off", 0, bod_en_ff);
      wake_up(0, n);
      chk("bod_back", 1, bod_en_ff);
      bus(1, 8'h33, 8'h00);
   endtask
   task t_scan;
      scan_port_fuse <= 1'b1;
      bus(1, 8'h34, 8'h00);
      cy(3);
      chk("scan_on", 1, scan_port_en_ff);
      chk("tdo_idle", 0, tdo_oe_ff);
      tap_shifting <= 1'b1;
      tdo_data <= 1'b1;
      cy(3);
      chk("tdo_drv", 1, tdo_oe_ff);
      chk("tdo_out", 1, tdo_out_ff);
      bus(1, 8'h34, 8'h80);
      cy(3);
      chk("scan_jtd", 0, scan_port_en_ff);
      bus(1, 8'h34, 8'h00);
      scan_port_fuse <= 1'b0;
      cy(3);
      chk("scan_fuse", 0, scan_port_en_ff);
   endtask
   initial
   begin
      rst = 1'b1;
      {avs_read, avs_write, crystal_sel, onchip_debug_fuse} = 4'h0;
      {scan_port_fuse, tap_shifting, comp_uses_ref, tdo_data} = 4'h0;
      {wdt_enabled, brownout_level_fuse, adc_enabled} = 3'h7;
      avs_address = 8'h00;
      avs_writedata = 32'h0;
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      t_regs;
      t_prr;
      t_refuse;
      t_modes;
      t_debug;
      t_brownout_sleep_off;
      t_scan;
      summarize;
   end
endmodule // sprc_power_ctrl_tb
